// ===== common/mbra_pkg.sv
// shared constants and types for the multi-byte register access block
package mbra_pkg;

  // register map, 7-bit serial addresses
  localparam logic [6:0] ADDR_CFG_A     = 7'h10;
  localparam logic [6:0] ADDR_DYN       = 7'h20;
  localparam logic [6:0] ADDR_PAGE      = 7'h64;
  localparam logic [6:0] ADDR_CFG_B     = 7'h70;
  localparam logic [6:0] ADDR_DIRECT_MAX = 7'h64;

  // register sizes in bytes
  localparam int         CFG_A_BYTES    = 4;
  localparam int         CFG_B_BYTES    = 2;
  localparam logic [6:0] DYN_BYTES      = 7'h04;
  localparam logic [6:0] CFG_A_SPAN     = 7'h04;
  localparam logic [6:0] CFG_B_SPAN     = 7'h02;

  // page that holds the paged configuration register
  localparam logic [7:0] PAGE_CFG_B     = 8'h01;

  // reset values
  localparam logic [31:0] RST_CFG_A     = 32'h00000000;
  localparam logic [15:0] RST_CFG_B     = 16'h0000;
  localparam logic [7:0]  RST_PAGE      = 8'h00;
  localparam logic [31:0] RST_SNAP      = 32'h00000000;

  // serial framing: bit counts within one command/data pair
  localparam logic [3:0] BIT_FIRST      = 4'h0;
  localparam logic [3:0] BIT_CMD_LAST   = 4'h7;
  localparam logic [3:0] BIT_DATA_FIRST = 4'h8;
  localparam logic [3:0] BIT_DATA_LAST  = 4'hF;

  // value of the first serial bit that marks a read
  localparam logic       CMD_READ       = 1'b1;

  typedef enum logic [1:0] {
    PH_IDLE = 2'b00,
    PH_CMD  = 2'b01,
    PH_DATA = 2'b10
  } mbra_phase_t;

  typedef struct packed {
    logic       rd;
    logic [6:0] addr;
  } mbra_cmd_t;

  typedef struct packed {
    logic cs_n;
    logic sck;
    logic si;
  } mbra_pins_t;

endpackage

// ===== src/mbra_stage_reg.sv
// staged multi-byte register: lower bytes held until the top byte commits all
`timescale 1ns/10ps
module mbra_stage_reg #(
  parameter int              NBYTES  = 4,
  parameter logic [8*NBYTES-1:0] RST_VAL = '0
) (
  // clock and reset
  input  wire logic                  clk,
  input  wire logic                  rstn,
  // byte write
  input  wire logic                  wr_en,
  input  wire logic [1:0]            idx,
  input  wire logic [7:0]            wdata,
  // committed value
  output logic      [8*NBYTES-1:0]   value_q
);

  // the top byte is never staged: it goes straight into the destination
  logic [7:0] stage_q [NBYTES-1];
  logic       commit;

  assign commit = wr_en && (idx == 2'(NBYTES - 1));

  genvar k;
  generate
    for (k = 0; k < NBYTES - 1; k++) begin : g_byte
      // lower bytes wait here, destination untouched
      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          stage_q[k] <= 8'h00;
        end else if (wr_en && (idx == 2'(k))) begin
          stage_q[k] <= wdata;
        end
      end

      always_ff @(posedge clk or negedge rstn) begin
        if (!rstn) begin
          value_q[8*k +: 8] <= RST_VAL[8*k +: 8];
        end else if (commit) begin
          value_q[8*k +: 8] <= stage_q[k];
        end
      end
    end
  endgenerate

  // top byte arrives: whole register changes in the same edge
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      value_q[8*NBYTES-1 -: 8] <= RST_VAL[8*NBYTES-1 -: 8];
    end else if (commit) begin
      value_q[8*NBYTES-1 -: 8] <= wdata;
    end
  end

endmodule

// ===== src/mbra_top.sv
// serial control port with atomic multi-byte register writes and read snapshots
`timescale 1ns/10ps
module mbra_top (
  // clock and reset
  input  wire logic               clk,
  input  wire logic               rstn,
  // serial port pins, synchronous to clk
  input  wire mbra_pkg::mbra_pins_t spi_in,
  output logic                    so_q,
  output logic                    so_oe_q,
  // device side
  input  wire logic [31:0]        live_val,
  output logic      [31:0]        cfg_a_q,
  output logic      [15:0]        cfg_b_q,
  output logic      [7:0]         page_q,
  output logic                    lsb_first_q
);

  mbra_pkg::mbra_phase_t phase_q;
  mbra_pkg::mbra_cmd_t   cmd_q;
  logic                  sck_q;
  logic                  cs_n_q;
  logic [3:0]            cnt_q;
  logic [7:0]            rx_q;
  logic [7:0]            tx_q;
  logic [31:0]           snap_q;
  logic                  cmd_done_q;
  logic                  wr_done_q;
  logic                  sck_rise;
  logic                  sck_fall;
  logic                  cs_start;
  logic                  visible;
  logic                  hit_a;
  logic                  hit_b;
  logic                  hit_dyn;
  logic [6:0]            off_a;
  logic [6:0]            off_b;
  logic [6:0]            off_dyn;
  logic [7:0]            rd_byte;

  // pins are already synchronous, so a single delay flop serves edge detection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      sck_q  <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      sck_q  <= spi_in.sck;
      cs_n_q <= spi_in.cs_n;
    end
  end

  assign cs_start = cs_n_q && !spi_in.cs_n;
  assign sck_rise = !spi_in.cs_n && !cs_n_q && spi_in.sck && !sck_q;
  assign sck_fall = !spi_in.cs_n && !cs_n_q && !spi_in.sck && sck_q;

  // bit order fixed for the whole selection
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      lsb_first_q <= 1'b0;
    end else if (cs_start) begin
      lsb_first_q <= spi_in.sck;
    end
  end

  // framing: each command byte is followed by exactly one data byte
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      phase_q <= mbra_pkg::PH_IDLE;
      cnt_q   <= mbra_pkg::BIT_FIRST;
    end else if (spi_in.cs_n) begin
      phase_q <= mbra_pkg::PH_IDLE;
      cnt_q   <= mbra_pkg::BIT_FIRST;
    end else if (cs_start) begin
      phase_q <= mbra_pkg::PH_CMD;
      cnt_q   <= mbra_pkg::BIT_FIRST;
    end else if (sck_rise) begin
      cnt_q <= cnt_q + 4'h1;
      case (phase_q)
        mbra_pkg::PH_CMD: begin
          if (cnt_q == mbra_pkg::BIT_CMD_LAST) begin
            phase_q <= mbra_pkg::PH_DATA;
          end
        end
        mbra_pkg::PH_DATA: begin
          // a further pair may follow in the same selection
          if (cnt_q == mbra_pkg::BIT_DATA_LAST) begin
            phase_q <= mbra_pkg::PH_CMD;
          end
        end
        default: begin
          phase_q <= mbra_pkg::PH_IDLE;
        end
      endcase
    end
  end

  // command byte: first bit is the direction, then seven address bits
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_q <= '0;
    end else if (sck_rise && phase_q == mbra_pkg::PH_CMD) begin
      if (cnt_q == mbra_pkg::BIT_FIRST) begin
        cmd_q.rd <= (spi_in.si == mbra_pkg::CMD_READ);
      end else if (lsb_first_q) begin
        cmd_q.addr <= {spi_in.si, cmd_q.addr[6:1]};
      end else begin
        cmd_q.addr <= {cmd_q.addr[5:0], spi_in.si};
      end
    end
  end

  // data byte shift-in; ignored on reads but harmless
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      rx_q <= 8'h00;
    end else if (sck_rise && phase_q == mbra_pkg::PH_DATA) begin
      if (lsb_first_q) begin
        rx_q <= {spi_in.si, rx_q[7:1]};
      end else begin
        rx_q <= {rx_q[6:0], spi_in.si};
      end
    end
  end

  // one-cycle event pulses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      cmd_done_q <= 1'b0;
      wr_done_q  <= 1'b0;
    end else begin
      cmd_done_q <= sck_rise && phase_q == mbra_pkg::PH_CMD
                    && cnt_q == mbra_pkg::BIT_CMD_LAST;
      wr_done_q  <= sck_rise && phase_q == mbra_pkg::PH_DATA
                    && cnt_q == mbra_pkg::BIT_DATA_LAST && !cmd_q.rd;
    end
  end

  // address decode
  assign visible = (cmd_q.addr <= mbra_pkg::ADDR_DIRECT_MAX)
                   || (page_q == mbra_pkg::PAGE_CFG_B);
  assign off_a   = cmd_q.addr - mbra_pkg::ADDR_CFG_A;
  assign off_b   = cmd_q.addr - mbra_pkg::ADDR_CFG_B;
  assign off_dyn = cmd_q.addr - mbra_pkg::ADDR_DYN;
  // lowest address holds the least significant byte
  assign hit_a   = cmd_q.addr >= mbra_pkg::ADDR_CFG_A
                   && off_a < mbra_pkg::CFG_A_SPAN;
  assign hit_b   = visible && cmd_q.addr >= mbra_pkg::ADDR_CFG_B
                   && off_b < mbra_pkg::CFG_B_SPAN;
  assign hit_dyn = cmd_q.addr >= mbra_pkg::ADDR_DYN
                   && off_dyn < mbra_pkg::DYN_BYTES;

  // page pointer changes only when written, so it spans multi-byte accesses
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      page_q <= mbra_pkg::RST_PAGE;
    end else if (wr_done_q && cmd_q.addr == mbra_pkg::ADDR_PAGE) begin
      page_q <= rx_q;
    end
  end

  // relies on the host writing the top byte last, after the lower bytes fill the staging bytes
  mbra_stage_reg #(
    .NBYTES  (mbra_pkg::CFG_A_BYTES),
    .RST_VAL (mbra_pkg::RST_CFG_A)
  ) u_cfg_a (
    .clk     (clk),
    .rstn    (rstn),
    .wr_en   (wr_done_q && hit_a),
    .idx     (off_a[1:0]),
    .wdata   (rx_q),
    .value_q (cfg_a_q)
  );

  mbra_stage_reg #(
    .NBYTES  (mbra_pkg::CFG_B_BYTES),
    .RST_VAL (mbra_pkg::RST_CFG_B)
  ) u_cfg_b (
    .clk     (clk),
    .rstn    (rstn),
    .wr_en   (wr_done_q && hit_b),
    .idx     (off_b[1:0]),
    .wdata   (rx_q),
    .value_q (cfg_b_q)
  );

  // snapshot so the four bytes all belong to one instant
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      snap_q <= mbra_pkg::RST_SNAP;
    end else if (cmd_done_q && cmd_q.rd && cmd_q.addr == mbra_pkg::ADDR_DYN) begin
      snap_q <= live_val;
    end
  end

  // read data mux; the low dynamic byte is taken live, the rest from the snapshot
  always_comb begin
    rd_byte = 8'h00;
    if (hit_dyn) begin
      if (off_dyn == 7'h00) begin
        rd_byte = live_val[7:0];
      end else begin
        rd_byte = snap_q[8*off_dyn[1:0] +: 8];
      end
    end else if (hit_a) begin
      rd_byte = cfg_a_q[8*off_a[1:0] +: 8];
    end else if (hit_b) begin
      rd_byte = cfg_b_q[8*off_b[0] +: 8];
    end else if (cmd_q.addr == mbra_pkg::ADDR_PAGE) begin
      rd_byte = page_q;
    end
  end

  // serial out: first bit presented right after the command, then shifted on
  // each falling sck; the fall right after the last address bit is skipped
  always_ff @(posedge clk or negedge rstn) begin
    if (!rstn) begin
      tx_q    <= 8'h00;
      so_q    <= 1'b0;
      so_oe_q <= 1'b0;
    end else if (spi_in.cs_n) begin
      so_oe_q <= 1'b0;
    end else if (cmd_done_q) begin
      tx_q    <= rd_byte;
      so_q    <= lsb_first_q ? rd_byte[0] : rd_byte[7];
      so_oe_q <= cmd_q.rd;
    end else if (sck_rise && phase_q == mbra_pkg::PH_DATA
                 && cnt_q == mbra_pkg::BIT_DATA_LAST) begin
      so_oe_q <= 1'b0;
    end else if (sck_fall && so_oe_q && phase_q == mbra_pkg::PH_DATA
                 && cnt_q != mbra_pkg::BIT_DATA_FIRST) begin
      if (lsb_first_q) begin
        tx_q <= {1'b0, tx_q[7:1]};
        so_q <= tx_q[1];
      end else begin
        tx_q <= {tx_q[6:0], 1'b0};
        so_q <= tx_q[6];
      end
    end
  end

endmodule

// ===== sim/mbra_host.sv
// serial host model that drives the control port pins
`timescale 1ns/10ps
module mbra_host (
  // clock
  input  wire logic            clk,
  // pins
  input  wire logic            so_q,
  output mbra_pkg::mbra_pins_t pins
);
  initial pins = 3'b100;
  // nb below 16 drops the select early to abort the frame
  task automatic xfer(input logic lsb, input logic rd, input logic [6:0] a,
                      input logic [7:0] d, input int nb, output logic [7:0] q);
    logic b;
    @(negedge clk);
    pins.sck = lsb;
    @(negedge clk);
    pins.cs_n = 1'b0;
    repeat (3) @(negedge clk);
    for (int i = 0; i < nb; i++) begin
      b = (i == 0) ? rd : (i < 8) ? a[lsb ? i - 1 : 7 - i] : d[lsb ? i - 8 : 15 - i];
      pins.sck = 1'b0;
      pins.si = b;
      repeat (3) @(negedge clk);
      if (i > 7) q[lsb ? i - 8 : 15 - i] = so_q;
      pins.sck = 1'b1;
      repeat (3) @(negedge clk);
    end
    // clock stands still and data leaves its last level between frames
    pins.cs_n = 1'b1;
    pins.sck = lsb;
    pins.si = ~b;
    repeat (3) @(negedge clk);
  endtask
endmodule

// ===== sim/mbra_properties.sv
// port checker for the multi-byte register access block
`timescale 1ns/10ps
module mbra_properties (
  // clock and reset
  input wire logic                 clk,
  input wire logic                 rstn,
  // observed ports
  input wire mbra_pkg::mbra_pins_t spi_in,
  input wire logic                 so_q,
  input wire logic                 so_oe_q,
  input wire logic [31:0]          live_val,
  input wire logic [31:0]          cfg_a_q,
  input wire logic [15:0]          cfg_b_q,
  input wire logic [7:0]           page_q,
  input wire logic                 lsb_first_q
);
  default clocking @(posedge clk); endclocking
  default disable iff (!rstn);
  sequence sel_start;
    $fell(spi_in.cs_n);
  endsequence
  sequence desel_held;
    spi_in.cs_n ##1 spi_in.cs_n;
  endsequence
  a_order_latch: assert property (sel_start |=> lsb_first_q == $past(spi_in.sck))
    else $error("bit order not taken from sck at select");
  a_order_hold: assert property (!spi_in.cs_n && !$past(spi_in.cs_n) |=> $stable(lsb_first_q))
    else $error("bit order moved inside a selection");
  a_cfg_a_commit: assert property ($changed(cfg_a_q) |-> !$past(spi_in.cs_n, 2))
    else $error("cfg a changed without a serial write");
  a_paged_commit: assert property ($changed(cfg_b_q) || $changed(page_q) |-> !$past(spi_in.cs_n, 2))
    else $error("paged register changed without a serial write");
  a_oe_needs_sel: assert property (so_oe_q |-> !$past(spi_in.cs_n))
    else $error("so driven while deselected");
  a_oe_drop: assert property (desel_held |-> !so_oe_q)
    else $error("so enable held after deselect");
  a_oe_start: assert property ($rose(so_oe_q) |-> $past(spi_in.sck, 2) && !$past(spi_in.sck, 3))
    else $error("read data began off the address rise");
  a_so_shift: assert property (so_oe_q && $past(so_oe_q) && $changed(so_q) |-> !spi_in.sck)
    else $error("so changed while sck high");
endmodule
bind mbra_top mbra_properties chk_u (.clk(clk), .rstn(rstn), .spi_in(spi_in), .so_q(so_q),
  .so_oe_q(so_oe_q), .live_val(live_val), .cfg_a_q(cfg_a_q), .cfg_b_q(cfg_b_q),
  .page_q(page_q), .lsb_first_q(lsb_first_q));

// ===== sim/tb.sv
// self-checking bench for the multi-byte register access block
`timescale 1ns/10ps
module tb;
  logic                 clk;
  logic                 rstn;
  mbra_pkg::mbra_pins_t spi_in;
  logic                 so_q;
  logic                 so_oe_q;
  logic [31:0]          live_val;
  logic [31:0]          cfg_a_q;
  logic [15:0]          cfg_b_q;
  logic [7:0]           page_q;
  logic                 lsb_first_q;
  logic [7:0]           q;
  int                   errors;
  int                   n_checks;
  mbra_top dut_u (.clk(clk), .rstn(rstn), .spi_in(spi_in), .so_q(so_q), .so_oe_q(so_oe_q),
    .live_val(live_val), .cfg_a_q(cfg_a_q), .cfg_b_q(cfg_b_q), .page_q(page_q),
    .lsb_first_q(lsb_first_q));
  mbra_host host_u (.clk(clk), .so_q(so_q), .pins(spi_in));
  always #50 clk = ~clk;
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_checks++;
    if (got !== exp) begin
      errors++;
      $display("BAD t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  task automatic end_sim();
    $display("checks=%0d errors=%0d", n_checks, errors);
    if (errors == 0 && n_checks > 0)
      $display("STATUS OK");
    else
      $display("STATUS NOT OK");
    $finish;
  endtask
  task automatic wr(input logic l, input logic [6:0] a, input logic [7:0] d);
    host_u.xfer(l, 1'b0, a, d, 16, q);
  endtask
  task automatic rd(input logic l, input logic [6:0] a);
    host_u.xfer(l, 1'b1, a, 8'h00, 16, q);
  endtask
  task automatic t_reset();
    chk(cfg_a_q, mbra_pkg::RST_CFG_A);
    chk(32'(cfg_b_q), 32'(mbra_pkg::RST_CFG_B));
    chk(32'(page_q), 32'(mbra_pkg::RST_PAGE));
    chk(32'({so_oe_q, lsb_first_q}), 32'h0);
  endtask
  task automatic t_stage();
    for (int i = 0; i < 3; i++) begin
      wr(1'b0, mbra_pkg::ADDR_CFG_A + 7'(i), 8'h11 * 8'(i + 1));
      chk(cfg_a_q, mbra_pkg::RST_CFG_A);
    end
    wr(1'b1, mbra_pkg::ADDR_CFG_A + 7'h03, 8'h44);
    chk(cfg_a_q, 32'h44332211);
  endtask
  task automatic t_abort();
    host_u.xfer(1'b0, 1'b0, mbra_pkg::ADDR_CFG_A + 7'h03, 8'h99, 12, q);
    chk(cfg_a_q, 32'h44332211);
    // a lone top byte commits whatever the staging still holds
    wr(1'b0, mbra_pkg::ADDR_CFG_A + 7'h03, 8'h55);
    chk(cfg_a_q, 32'h55332211);
    wr(1'b0, mbra_pkg::ADDR_DYN, 8'hFF);
    rd(1'b0, 7'h40);
    chk(32'(q), 32'h0);
  endtask
  task automatic t_dyn();
    live_val = 32'hA1B2C3D4;
    rd(1'b1, mbra_pkg::ADDR_DYN);
    chk(32'(q), 32'hD4);
    chk(32'(lsb_first_q), 32'h1);
    live_val = 32'h0F1E2D3C;
    for (int i = 1; i < 4; i++) begin
      rd(i[0], mbra_pkg::ADDR_DYN + 7'(i));
      chk(32'(q), (32'hA1B2C3D4 >> (8 * i)) & 32'hFF);
    end
    rd(1'b0, mbra_pkg::ADDR_DYN);
    chk(32'(q), 32'h3C);
    chk(32'(lsb_first_q), 32'h0);
  endtask
  task automatic t_page();
    wr(1'b0, mbra_pkg::ADDR_CFG_B + 7'h01, 8'h77);
    chk(32'(cfg_b_q), 32'(mbra_pkg::RST_CFG_B));
    wr(1'b0, mbra_pkg::ADDR_PAGE, mbra_pkg::PAGE_CFG_B);
    wr(1'b1, mbra_pkg::ADDR_CFG_B, 8'h5A);
    wr(1'b1, mbra_pkg::ADDR_CFG_B + 7'h01, 8'hC3);
    chk(32'(cfg_b_q), 32'h0000C35A);
    rd(1'b0, mbra_pkg::ADDR_PAGE);
    chk(32'(q), 32'(mbra_pkg::PAGE_CFG_B));
  endtask
  initial begin
    clk = 1'b0;
    rstn = 1'b0;
    live_val = 32'h0;
    errors = 0;
    n_checks = 0;
    repeat (4) @(negedge clk);
    rstn = 1'b1;
    @(negedge clk);
    t_reset();
    t_stage();
    t_abort();
    t_dyn();
    t_page();
    end_sim();
  end
  // about twenty frames of some 104 cycles each fit well inside this span
  initial begin
    repeat (10000) @(posedge clk);
    errors++;
    end_sim();
  end
endmodule
